// file: hw/ipw1_top.v
// Our own choices: the APB register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "ipw1_consts.vh"

module ipw1_top (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	input  wire [3:0]  src_pending,
	output reg  [2:0]  win_level_r,
	output reg  [1:0]  win_source_r,
	output reg         win_valid_r
);

	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	wire        setup_rd;
	wire        access_wr;
	wire        hit_prio;
	wire        hit_status;
	wire        hit_pending;

	// Read data loads in the setup cycle
	assign setup_rd    = psel & ~penable & ~pwrite;

	// Writes land in the access cycle
	assign access_wr   = psel & penable & pwrite;

	// Address matches
	assign hit_prio    = (paddr == `IPW1_ADDR_PRIO);
	assign hit_status  = (paddr == `IPW1_ADDR_STATUS);
	assign hit_pending = (paddr == `IPW1_ADDR_PENDING);

	// ----------------------------------------
	// Bus response
	// ----------------------------------------
	// No wait states, no error answer
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= 1'b1;
			pslverr <= 1'b0;
		end
	end

	// ----------------------------------------
	// Priority fields
	// ----------------------------------------
	// Index 0 timer three, 1 sync error,
	// 2 sync event, 3 serial receive
	wire [15:0] word_view;
	wire [11:0] elig_flat;

	genvar g;

	generate
		for (g = 0; g < 4; g = g + 1) begin : g_field
			reg [2:0] code_r;

			always @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					code_r <= `IPW1_FIELD_RESET;
				end else if (access_wr && hit_prio) begin
					code_r <= pwdata[g*4 +: 3];
				end
			end

			assign word_view[g*4 +: 4] = {1'b0, code_r};

			assign elig_flat[g*3 +: 3] = src_pending[g] ? code_r : `IPW1_PRIO_OFF;
		end
	endgenerate

	// ----------------------------------------
	// Arbitration
	// ----------------------------------------
	reg [2:0] best_lvl;
	reg [1:0] best_src;
	reg       best_ok;
	integer   i;

	// Ties go to the lowest index
	always @* begin
		best_lvl = `IPW1_PRIO_OFF;
		best_src = 2'h0;
		best_ok  = 1'b0;
		for (i = 0; i < 4; i = i + 1) begin
			if (elig_flat[i*3 +: 3] != `IPW1_PRIO_OFF &&
				elig_flat[i*3 +: 3] > best_lvl) begin
				best_lvl = elig_flat[i*3 +: 3];
				best_src = i[1:0];
				best_ok  = 1'b1;
			end
		end
	end

	// ----------------------------------------
	// Winner registers
	// ----------------------------------------
	// One cycle behind pending and codes
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			win_level_r  <= 3'h0;
			win_source_r <= 2'h0;
			win_valid_r  <= 1'b0;
		end else begin
			win_level_r  <= best_lvl;
			win_source_r <= best_src;
			win_valid_r  <= best_ok;
		end
	end

	// ----------------------------------------
	// Read data
	// ----------------------------------------
	// Holds until the next read setup
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
		end else if (setup_rd) begin
			if (hit_prio) begin
				prdata <= {16'h0000, word_view & `IPW1_IMPL_MASK};
			end else if (hit_status) begin
				prdata <= {26'h0000000, best_ok, best_src, best_lvl};
			end else if (hit_pending) begin
				prdata <= {28'h0000000, src_pending};
			end else begin
				prdata <= 32'h00000000;
			end
		end
	end

endmodule // ipw1_top

`default_nettype wire

// file: hw/ipw1_consts.vh
// Behaviour
// - The sync serial event priority is a read/write 3-bit field at bits 10 to 8.
// - A priority code of 000 disables its source so it never takes part in arbitration.
// - Codes 001 to 111 rank the source at levels 1 to 7 numerically.
// - Bits 15, 11, 7 and 3 are unimplemented, ignore writes and read as zero.
// - Level 7 is the highest priority when pending sources are compared.
`ifndef IPW1_CONSTS_VH
`define IPW1_CONSTS_VH

// ----------------------------------------
// Register map
// ----------------------------------------
`define IPW1_ADDR_PRIO     12'h000
`define IPW1_ADDR_STATUS   12'h004
`define IPW1_ADDR_PENDING  12'h008

// ----------------------------------------
// Field layout
// ----------------------------------------
`define IPW1_SER_RX_LSB    12
`define IPW1_SS_EVT_LSB    8
`define IPW1_SS_ERR_LSB    4
`define IPW1_TMR3_LSB      0
`define IPW1_IMPL_MASK     16'h7777
`define IPW1_FIELD_RESET   3'h4
`define IPW1_PRIO_OFF      3'h0

`endif

// file: testbench/ipw1_checker.sv
`timescale 1ns/10ps
`default_nettype none
module ipw1_checker (
	input wire logic pclk, presetn, psel, penable, pwrite, win_valid_r, pready, pslverr,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata, prdata,
	input wire logic [3:0] src_pending,
	input wire logic [2:0] win_level_r
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_w; psel && penable && pwrite && paddr == 12'h000; endsequence
	sequence s_r; psel && !penable && !pwrite && paddr == 12'h000; endsequence
	sequence s_ru; psel && !penable && !pwrite && paddr == 12'h00C; endsequence
	AST_WR_RD: assert property (s_w ##2 s_r |=>
		prdata[15:0] == ($past(pwdata[15:0], 3) & 16'h7777)) else $error("bad readback");
	AST_UNMAP: assert property (s_ru |=> prdata == 32'h0)
		else $error("unmapped read not zero");
	AST_NONE: assert property (!win_valid_r |-> win_level_r == 3'h0)
		else $error("level without winner");
	AST_PAD: assert property (s_r |=> (prdata & 32'hFFFF8888) == 32'h0)
		else $error("pad bits set");
	AST_OFF: assert property (src_pending == 4'h0 |=> !win_valid_r)
		else $error("idle winner");
	AST_LVL: assert property (win_valid_r |-> win_level_r != 3'h0)
		else $error("zero level won");
endmodule // ipw1_checker
bind ipw1_top ipw1_checker u_chk (.*);
`default_nettype wire

// file: testbench/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, win_valid_r;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd;
	logic [3:0] src_pending = 0;
	logic [2:0] win_level_r;
	logic [1:0] win_source_r;
	int mismatches = 0, compares = 0, cyc = 0;
	ipw1_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .src_pending(src_pending), .win_level_r(win_level_r),
		.win_source_r(win_source_r), .win_valid_r(win_valid_r));
	always #2 pclk = ~pclk;
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 500) begin
			mismatches++;
			end_sim();
		end
	end
	task end_sim;
		if (mismatches == 0 && compares > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task ck(input string n, input logic [31:0] e, input logic [31:0] s);
		compares++;
		if (s !== e) begin
			mismatches++;
			$display("BAD %s exp %h got %h", n, e, s);
		end
	endtask
	task ap(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk) penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		penable <= 0;
		psel <= 0;
		@(posedge pclk);
	endtask
	task win(input logic [3:0] p, input logic [5:0] e);
		src_pending <= p;
		repeat (2) @(posedge pclk);
		@(negedge pclk);
		ck("win", {26'h0, e}, {26'h0, win_valid_r, win_source_r, win_level_r});
		@(posedge pclk);
	endtask
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		ap(0, 12'h000, 0); ck("reset", 32'h4444, rd);
		ap(1, 12'h000, 32'hFFFFFFFF); ap(0, 12'h000, 0); ck("pad", 32'h7777, rd);
		ap(1, 12'h000, 32'h1357); ap(0, 12'h000, 0); ck("word", 32'h1357, rd);
		win(4'hF, 6'h27);
		win(4'hE, 6'h2D);
		win(4'h8, 6'h39);
		ap(1, 12'h000, 32'h7); ap(0, 12'h00C, 0); ck("unmapped", 32'h0, rd);
		ap(0, 12'h000, 0); ck("timer", 32'h0007, rd);
		win(4'hE, 6'h00);
		end_sim();
	end
endmodule // tb_top
`default_nettype wire
